// [rtl/iotdl_cfg.svh]
// Constants for the I/O tap delay line pair
`ifndef IOTDL_CFG_SVH
`define IOTDL_CFG_SVH
`define IOTDL_TAP_W       5
`define IOTDL_TAP_MAX     5'h1f
`define IOTDL_TAP_RST     5'h00
`define IOTDL_LINE_PS     1800
`define IOTDL_CHAIN_PS    3600
`define IOTDL_CLK_NS      40
// SDR launch register variant codes, in the order of iotdl_sdr_t
`define IOTDL_REG_SDR_AC  2'h0
`define IOTDL_REG_SDR_AP  2'h1
`define IOTDL_REG_SDR_SR  2'h2
`define IOTDL_REG_SDR_SS  2'h3
`endif

// [rtl/iotdl_pkg.sv]
// Types for the I/O tap delay line pair
package iotdl_pkg;
`include "iotdl_cfg.svh"
   typedef logic [`IOTDL_TAP_W-1:0] iotdl_tap_t;
   typedef enum logic [1:0] {
      IOTDL_PATH_BYPASS = 2'h0,
      IOTDL_PATH_SDR    = 2'h1,
      IOTDL_PATH_DDR    = 2'h3
   } iotdl_path_t;
   typedef enum logic [1:0] {
      IOTDL_SDR_ASYNC_CLEAR  = 2'h0,
      IOTDL_SDR_ASYNC_PRESET = 2'h1,
      IOTDL_SDR_SYNC_RESET   = 2'h2,
      IOTDL_SDR_SYNC_SET     = 2'h3
   } iotdl_sdr_t;
endpackage : iotdl_pkg

// [rtl/iotdl_if.sv]
// Interface joining pin logic and the fabric tap controller
interface iotdl_if;
   import iotdl_pkg::*;
   logic             tap_clk;
   logic             tap_rst;
   iotdl_tap_t       in_tap_load_value;
   logic             in_load;
   logic             in_step_en;
   logic             in_step_up;
   iotdl_tap_t       in_tap_readback;
   iotdl_tap_t       out_tap_load_value;
   logic             out_load;
   logic             out_step_en;
   logic             out_step_up;
   iotdl_tap_t       out_tap_readback;
   logic             cascade;
   iotdl_path_t      path_mode;
   iotdl_sdr_t       sdr_variant;
   modport pin_end (
      input  tap_clk, tap_rst, in_tap_load_value, in_load, in_step_en, in_step_up,
      input  out_tap_load_value, out_load, out_step_en, out_step_up, cascade,
      input  path_mode, sdr_variant,
      output in_tap_readback, out_tap_readback
   );
   modport fabric_end (
      output tap_clk, tap_rst, in_tap_load_value, in_load, in_step_en, in_step_up,
      output out_tap_load_value, out_load, out_step_en, out_step_up, cascade,
      output path_mode, sdr_variant,
      input  in_tap_readback, out_tap_readback
   );
endinterface : iotdl_if

// [rtl/iotdl_pin.sv]
// Per-pin I/O logic: SDR/DDR registers and two 32-tap delay lines
`include "iotdl_cfg.svh"

module iotdl_pin #(
   parameter int LINE_TAPS = 32
) (
   input  wire logic  mclk,
   input  wire logic  rst,
   iotdl_if.pin_end   ctl,
   input  wire logic  pad_input,
   input  wire logic  launch_data_in,
   input  wire logic  launch_data_in2,
   input  wire logic  tristate_ctrl_in,
   input  wire logic  tristate_ctrl_in2,
   input  wire logic  reg_ce,
   input  wire logic  async_sr,
   output logic       capture_rise,
   output logic       capture_fall,
   output logic       delayed_output,
   output logic       tristate_ctrl_delayed,
   output logic       pad_data_out,
   output logic       chain_forward_out
);
   import iotdl_pkg::*;

   // The tap code is five bits wide, so the line cannot be longer or shorter
   if (LINE_TAPS != (1 << `IOTDL_TAP_W)) begin : g_bad_taps
      $error("iotdl_pin: only 32 taps supported");
   end

   // ==========================================================
   // Tap counters
   typedef struct packed {
      iotdl_tap_t in_tap;
      iotdl_tap_t out_tap;
   } iotdl_tapst_t;

   iotdl_tapst_t tq;
   iotdl_tapst_t next_tq;

   function automatic iotdl_tap_t iotdl_next_tap(iotdl_tap_t cur, logic ld, iotdl_tap_t val,
                                                 logic en, logic up);
      iotdl_tap_t r;
      r = cur;
      if (ld) begin
         r = val;
      end else if (en) begin
         if (up && cur != `IOTDL_TAP_MAX) begin
            r = cur + 5'h01;
         end else if (!up && cur != 5'h00) begin
            r = cur - 5'h01;
         end
      end
      return r;
   endfunction : iotdl_next_tap

   always_comb begin
      next_tq.in_tap  = iotdl_next_tap(tq.in_tap, ctl.in_load, ctl.in_tap_load_value,
                                       ctl.in_step_en, ctl.in_step_up);
      next_tq.out_tap = iotdl_next_tap(tq.out_tap, ctl.out_load, ctl.out_tap_load_value,
                                       ctl.out_step_en, ctl.out_step_up);
   end

   // Tap clock only samples the controls; reset needs no clock edge
   always_ff @(posedge ctl.tap_clk or posedge ctl.tap_rst) begin
      if (ctl.tap_rst) begin
         tq <= {`IOTDL_TAP_RST, `IOTDL_TAP_RST};
      end else begin
         tq <= next_tq;
      end
   end

   assign ctl.in_tap_readback  = tq.in_tap;
   assign ctl.out_tap_readback = tq.out_tap;

   // ==========================================================
   // Delay lines: one mclk stage per tap plus the tap itself,
   // a cycle model of an analog line (real delay is below one period)
   typedef struct packed {
      logic [1:0]  pad_sync;
      logic [LINE_TAPS-1:0] in_line;
      logic [LINE_TAPS-1:0] out_d_line;
      logic [LINE_TAPS-1:0] out_t_line;
      logic        cap_r;
      logic        cap_f;
      logic        sdr_d;
      logic        sdr_t;
      logic        ddr_d1;
      logic        ddr_d2;
      logic        ddr_t1;
      logic        ddr_t2;
      logic        phase;
      logic        dout;
      logic        tout;
      logic        pout;
      logic        fwd;
   } iotdl_st_t;

   iotdl_st_t q;
   iotdl_st_t next_q;
   logic      d_src;
   logic      t_src;
   logic      in_tap_out;
   logic      out_tap_d;

   // Clear and preset act on the next mclk edge: a limit of the one-clock
   // model, so the four variants differ only in the level that is forced
   function automatic logic iotdl_sdr(iotdl_sdr_t v, logic cur, logic d, logic ce, logic sr);
      logic r;
      r = ce ? d : cur;
      if (sr) begin
         r = (v == IOTDL_SDR_ASYNC_PRESET || v == IOTDL_SDR_SYNC_SET);
      end
      return r;
   endfunction : iotdl_sdr

   function automatic logic iotdl_tap_sel(logic [LINE_TAPS-1:0] stages, iotdl_tap_t tap);
      return stages[tap];
   endfunction : iotdl_tap_sel

   assign in_tap_out = iotdl_tap_sel(q.in_line, tq.in_tap);
   assign out_tap_d  = iotdl_tap_sel(q.out_d_line, tq.out_tap);

   // ==========================================================
   // Launch path select
   // One path mode serves data and tristate together
   always_comb begin
      unique case (ctl.path_mode)
         IOTDL_PATH_SDR: begin
            d_src = q.sdr_d;
            t_src = q.sdr_t;
         end
         IOTDL_PATH_DDR: begin
            d_src = q.phase ? q.ddr_d2 : q.ddr_d1;
            t_src = q.phase ? q.ddr_t2 : q.ddr_t1;
         end
         default: begin
            d_src = launch_data_in;
            t_src = tristate_ctrl_in;
         end
      endcase
   end

   always_comb begin
      next_q          = q;
      next_q.pad_sync = {q.pad_sync[0], pad_input};
      next_q.in_line  = {q.in_line[LINE_TAPS-2:0], q.pad_sync[1]};
      // Chained: output line carries input data, tristate held released
      next_q.out_d_line = {q.out_d_line[LINE_TAPS-2:0], ctl.cascade ? in_tap_out : d_src};
      next_q.out_t_line = {q.out_t_line[LINE_TAPS-2:0], ctl.cascade ? 1'b1 : t_src};
      next_q.cap_r    = q.pad_sync[1];
      next_q.cap_f    = q.cap_r;
      next_q.sdr_d    = iotdl_sdr(ctl.sdr_variant, q.sdr_d, launch_data_in, reg_ce,
                                  async_sr);
      next_q.sdr_t    = iotdl_sdr(ctl.sdr_variant, q.sdr_t, tristate_ctrl_in, reg_ce,
                                  async_sr);
      next_q.phase    = ~q.phase;
      // Phase 0 takes both launch bits, so each pair leaves second bit (launch_data_in2) first
      if (!q.phase) begin
         next_q.ddr_d1 = launch_data_in;
         next_q.ddr_d2 = launch_data_in2;
         next_q.ddr_t1 = tristate_ctrl_in;
         next_q.ddr_t2 = tristate_ctrl_in2;
      end
      // Input path result; when chained it returns through the output line
      next_q.dout = ctl.cascade ? out_tap_d : in_tap_out;
      next_q.tout = iotdl_tap_sel(q.out_t_line, tq.out_tap);
      next_q.pout = out_tap_d;
      next_q.fwd  = in_tap_out;
   end

   // ==========================================================
   // Datapath registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   assign capture_rise          = q.cap_r;
   assign capture_fall          = q.cap_f;
   assign delayed_output        = q.dout;
   assign tristate_ctrl_delayed = q.tout;
   assign pad_data_out          = q.pout;
   assign chain_forward_out     = q.fwd;
endmodule : iotdl_pin

// [rtl/iotdl_fabric.sv]
// Fabric-side tap controller driving both delay lines
module iotdl_fabric (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   iotdl_if.fabric_end               ctl,
   input  wire logic                 user_sel_out,
   input  wire logic                 user_load,
   input  wire logic                 user_step,
   input  wire logic                 user_up,
   input  iotdl_pkg::iotdl_tap_t     user_value,
   input  wire logic                 user_chain,
   input  iotdl_pkg::iotdl_path_t    user_path,
   input  iotdl_pkg::iotdl_sdr_t     user_sdr,
   output iotdl_pkg::iotdl_tap_t     user_in_tap,
   output iotdl_pkg::iotdl_tap_t     user_out_tap
);
   import iotdl_pkg::*;

   // ==========================================================
   // Registered controls, stable for the tap clock (mclk)
   typedef struct packed {
      iotdl_tap_t  value;
      logic        in_ld;
      logic        in_en;
      logic        out_ld;
      logic        out_en;
      logic        up;
      logic        chain;
      iotdl_path_t path;
      iotdl_sdr_t  sdr;
      iotdl_tap_t  in_rb;
      iotdl_tap_t  out_rb;
   } iotdl_fst_t;

   iotdl_fst_t q;
   iotdl_fst_t next_q;

   always_comb begin
      next_q        = q;
      next_q.value  = user_value;
      next_q.in_ld  = user_load & ~user_sel_out;
      next_q.in_en  = user_step & ~user_sel_out;
      next_q.out_ld = user_load & user_sel_out;
      next_q.out_en = user_step & user_sel_out;
      next_q.up     = user_up;
      next_q.chain  = user_chain;
      // Chaining is for input-only pins: force bypass launch style
      next_q.path   = user_chain ? IOTDL_PATH_BYPASS : user_path;
      next_q.sdr    = user_sdr;
      next_q.in_rb  = ctl.in_tap_readback;
      next_q.out_rb = ctl.out_tap_readback;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign ctl.tap_clk            = mclk;
   assign ctl.tap_rst            = rst;
   assign ctl.in_tap_load_value  = q.value;
   assign ctl.out_tap_load_value = q.value;
   assign ctl.in_load            = q.in_ld;
   assign ctl.in_step_en         = q.in_en;
   assign ctl.in_step_up         = q.up;
   assign ctl.out_load           = q.out_ld;
   assign ctl.out_step_en        = q.out_en;
   assign ctl.out_step_up        = q.up;
   assign ctl.cascade            = q.chain;
   assign ctl.path_mode          = q.path;
   assign ctl.sdr_variant        = q.sdr;
   assign user_in_tap            = q.in_rb;
   assign user_out_tap           = q.out_rb;
endmodule : iotdl_fabric

// [verification/iotdl_properties.sv]
// Properties of the tap control interface between fabric and pin logic
module iotdl_properties (
   input wire logic              tap_clk,
   input wire logic              tap_rst,
   input iotdl_pkg::iotdl_tap_t  in_tap_load_value,
   input wire logic              in_load,
   input wire logic              in_step_en,
   input wire logic              in_step_up,
   input iotdl_pkg::iotdl_tap_t  in_tap_readback,
   input iotdl_pkg::iotdl_tap_t  out_tap_load_value,
   input wire logic              out_load,
   input wire logic              out_step_en,
   input wire logic              out_step_up,
   input iotdl_pkg::iotdl_tap_t  out_tap_readback,
   input wire logic              cascade,
   input iotdl_pkg::iotdl_path_t path_mode
);
   import iotdl_pkg::*;
   // =====================================================
   // Tap stepping, loading and reset; path mode while chained
   default clocking cb @(posedge tap_clk); endclocking
   default disable iff (tap_rst);
   AST_IN_LOAD: assert property (in_load |=> in_tap_readback == $past(in_tap_load_value))
      else $error("input line load not taken");
   AST_OUT_LOAD: assert property (out_load |=> out_tap_readback == $past(out_tap_load_value))
      else $error("output line load not taken");
   AST_IN_UP: assert property (!in_load && in_step_en && in_step_up && in_tap_readback != 5'h1f
      |=> in_tap_readback == $past(in_tap_readback) + 5'h01) else $error("input step up wrong");
   AST_IN_DN: assert property (!in_load && in_step_en && !in_step_up && in_tap_readback != 5'h00
      |=> in_tap_readback == $past(in_tap_readback) - 5'h01) else $error("input step down wrong");
   AST_OUT_STEP: assert property (!out_load && out_step_en && out_tap_readback != 5'h00
      && out_tap_readback != 5'h1f |=> out_tap_readback == (out_step_up ? $past(out_tap_readback)
      + 5'h01 : $past(out_tap_readback) - 5'h01)) else $error("output step wrong");
   AST_IN_SAT: assert property (!in_load && in_step_en && (in_step_up ? in_tap_readback == 5'h1f
      : in_tap_readback == 5'h00) |=> $stable(in_tap_readback)) else $error("input tap wrapped");
   AST_OUT_SAT: assert property (!out_load && out_step_en && (out_step_up ? out_tap_readback
      == 5'h1f : out_tap_readback == 5'h00) |=> $stable(out_tap_readback))
      else $error("output tap wrapped");
   AST_IN_HOLD: assert property (!in_load && !in_step_en |=> $stable(in_tap_readback))
      else $error("input tap moved without control");
   AST_OUT_HOLD: assert property (!out_load && !out_step_en |=> $stable(out_tap_readback))
      else $error("output tap moved without control");
   AST_RST: assert property (disable iff (1'b0) tap_rst |-> in_tap_readback == 5'h00
      && out_tap_readback == 5'h00) else $error("taps not cleared by reset");
   AST_CHAIN: assert property (cascade |-> path_mode == IOTDL_PATH_BYPASS)
      else $error("registered path while chained");
   cover property (in_load && in_step_en);
   cover property (in_step_en && in_step_up && in_tap_readback == 5'h1f);
   cover property (cascade);
   cover property (out_step_en && !out_step_up && out_tap_readback == 5'h00);
endmodule : iotdl_properties

// [verification/io_tap_delay_line_pair_tb.sv]
// Testbench for the I/O tap delay line pair
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   $display("mismatch %s expected %h seen %h", n, e, g); miscompares++; end end
module io_tap_delay_line_pair_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import iotdl_pkg::*;
   logic        mclk, rst, user_sel_out, user_load, user_step, user_up, user_chain;
   iotdl_tap_t  user_value, user_in_tap, user_out_tap;
   iotdl_path_t user_path;
   iotdl_sdr_t  user_sdr;
   logic        pad_input, d1, d2, t1, t2, reg_ce, async_sr;
   logic        cap_r, cap_f, dly_out, tri_dly, pad_out, fwd_out;
   int          miscompares = 0, checked = 0;
   iotdl_if bus ();
   iotdl_pin iotdl_pin_inst (.mclk(mclk), .rst(rst), .ctl(bus), .pad_input(pad_input),
      .launch_data_in(d1), .launch_data_in2(d2), .tristate_ctrl_in(t1), .tristate_ctrl_in2(t2),
      .reg_ce(reg_ce), .async_sr(async_sr), .capture_rise(cap_r), .capture_fall(cap_f),
      .delayed_output(dly_out), .tristate_ctrl_delayed(tri_dly), .pad_data_out(pad_out),
      .chain_forward_out(fwd_out));
   iotdl_fabric iotdl_fabric_inst (.mclk(mclk), .rst(rst), .ctl(bus), .user_sel_out(user_sel_out),
      .user_load(user_load), .user_step(user_step), .user_up(user_up), .user_value(user_value),
      .user_chain(user_chain), .user_path(user_path), .user_sdr(user_sdr),
      .user_in_tap(user_in_tap), .user_out_tap(user_out_tap));
   iotdl_properties iotdl_properties_inst (.tap_clk(bus.tap_clk), .tap_rst(bus.tap_rst),
      .in_tap_load_value(bus.in_tap_load_value), .in_load(bus.in_load),
      .in_step_en(bus.in_step_en), .in_step_up(bus.in_step_up),
      .in_tap_readback(bus.in_tap_readback), .out_tap_load_value(bus.out_tap_load_value),
      .out_load(bus.out_load), .out_step_en(bus.out_step_en), .out_step_up(bus.out_step_up),
      .out_tap_readback(bus.out_tap_readback), .cascade(bus.cascade), .path_mode(bus.path_mode));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // =====================================================
   // Shared tasks
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // Controls are levels: n cycles high gives n steps, fewer where the tap saturates at 5'h1f or 5'h00
   task automatic drive(input logic sel, ld, st, up, input iotdl_tap_t v, input int n);
      @(posedge mclk);
      {user_sel_out, user_load, user_step, user_up, user_value} <= {sel, ld, st, up, v};
      repeat (n) @(posedge mclk);
      {user_load, user_step} <= 2'h0;
      repeat (5) @(posedge mclk);
   endtask : drive
   task automatic check_taps(input iotdl_tap_t iv, input iotdl_tap_t ov);
      `CHK("user_in_tap", iv, user_in_tap)
      `CHK("user_out_tap", ov, user_out_tap)
      `CHK("in_tap_readback", iv, bus.in_tap_readback)
      `CHK("out_tap_readback", ov, bus.out_tap_readback)
   endtask : check_taps
   // =====================================================
   // Scenarios
   task automatic t_taps;
      drive(1'b0, 1'b1, 1'b0, 1'b0, 5'h15, 1);
      drive(1'b1, 1'b1, 1'b0, 1'b0, 5'h0a, 1);
      check_taps(5'h15, 5'h0a);
      drive(1'b0, 1'b0, 1'b1, 1'b1, 5'h00, 3);
      drive(1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 1);
      drive(1'b1, 1'b0, 1'b1, 1'b0, 5'h00, 2);
      check_taps(5'h17, 5'h08);
      drive(1'b0, 1'b1, 1'b0, 1'b0, 5'h1e, 1);
      drive(1'b0, 1'b0, 1'b1, 1'b1, 5'h00, 4);
      drive(1'b1, 1'b1, 1'b0, 1'b0, 5'h01, 1);
      drive(1'b1, 1'b0, 1'b1, 1'b0, 5'h00, 3);
      check_taps(5'h1f, 5'h00);
      drive(1'b0, 1'b1, 1'b1, 1'b1, 5'h07, 1);
      drive(1'b1, 1'b1, 1'b1, 1'b0, 5'h13, 2);
      check_taps(5'h07, 5'h13);
   endtask : t_taps
   // Settled levels, DDR launch alternation, SDR forced levels and enable hold: the tap delay itself is not timed here
   task automatic t_path;
      iotdl_path_t pm [3] = '{IOTDL_PATH_BYPASS, IOTDL_PATH_SDR, IOTDL_PATH_DDR};
      logic [1:0]  pair;
      drive(1'b1, 1'b1, 1'b0, 1'b0, 5'h1f, 1);
      foreach (pm[i]) begin
         for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            user_path <= pm[i];
            user_sdr  <= iotdl_sdr_t'(s);
            {pad_input, d1, d2, t1, t2, async_sr} <= {3'h7, s[0], s[0], 1'b0};
            repeat (80) @(posedge mclk);
            `CHK("delayed_output", 1'b1, dly_out)
            `CHK("pad_data_out", 1'b1, pad_out)
            `CHK("tristate_ctrl_delayed", s[0], tri_dly)
            if (pm[i] == IOTDL_PATH_DDR) begin
               `CHK("capture_rise", 1'b1, cap_r)
               `CHK("capture_fall", 1'b1, cap_f)
               // Second launch bit low: the pad must alternate every cycle
               d2 <= 1'b0;
               repeat (80) @(posedge mclk);
               pair[0] = pad_out;
               @(posedge mclk);
               pair[1] = pad_out;
               `CHK("ddr_launch_alternation", 1'b1, ^pair)
            end
            if (pm[i] == IOTDL_PATH_SDR) begin
               async_sr <= 1'b1;
               repeat (80) @(posedge mclk);
               `CHK("sdr_variant_output", s[0], pad_out)
               `CHK("sdr_variant_tristate", s[0], tri_dly)
               // Enable low: the forced level must hold against the data input
               {async_sr, reg_ce} <= 2'h0;
               repeat (80) @(posedge mclk);
               `CHK("sdr_enable_hold", s[0], pad_out)
               reg_ce <= 1'b1;
            end
         end
      end
   endtask : t_path
   task automatic t_chain;
      for (int v = 1; v >= 0; v--) begin
         @(posedge mclk);
         user_path  <= IOTDL_PATH_BYPASS;
         user_chain <= 1'b1;
         async_sr   <= 1'b0;
         {pad_input, d1, d2, t1, t2} <= {v[0], 4'h0};
         repeat (150) @(posedge mclk);
         `CHK("cascade", 1'b1, bus.cascade)
         `CHK("chain_forward_out", v[0], fwd_out)
         `CHK("delayed_output", v[0], dly_out)
         `CHK("tristate_ctrl_delayed", 1'b1, tri_dly)
      end
   endtask : t_chain
   task automatic t_rst;
      @(posedge mclk);
      {rst, user_chain} <= 2'h2;
      repeat (3) @(posedge mclk);
      `CHK("in_tap_readback", 5'h00, bus.in_tap_readback)
      `CHK("out_tap_readback", 5'h00, bus.out_tap_readback)
      rst <= 1'b0;
      repeat (5) @(posedge mclk);
      check_taps(5'h00, 5'h00);
   endtask : t_rst
   initial begin
      // Non-blocking, so the asynchronous tap reset sees its edge at time zero
      {rst, user_sel_out, user_load, user_step, user_up, user_chain} <= 6'h20;
      user_value <= 5'h00;
      user_path  <= IOTDL_PATH_BYPASS;
      user_sdr   <= IOTDL_SDR_ASYNC_CLEAR;
      {pad_input, d1, d2, t1, t2, async_sr, reg_ce} <= 7'h01;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_taps();
      t_path();
      t_chain();
      t_rst();
      finish_test();
   end
   // Span is several times the expected run of under 3500 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      finish_test();
   end
endmodule : io_tap_delay_line_pair_tb
